/* gxr_expander.sv */
// gxr_expander: two-wire slave gpio expander with sixteen pins in two banks
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
module gxr_expander #(
  parameter logic USE_ADDR_PINS = 1'b0,       // 1: address from pins
  parameter logic [6:0] FIXED_ADDR = 7'h20,   // plain default
  parameter logic [2:0] PIN_ADDR_HI = 3'h2    // upper bits when pins used
) (
  input wire logic clk_i,                       // system clock
  input wire logic srst_i,                      // sync reset, high
  input wire logic reset_n_pin_i,               // reset pin, low
  input wire logic [3:0] addr_select_pin_i,     // address pins
  input wire logic scl_i,                       // serial clock pin
  input wire logic sda_i,                       // serial data in
  output logic sda_o,                           // serial data out
  output logic sda_oe_o,                        // serial data drive
  input wire logic [7:0] bank0_pin_i,           // bank 0 pin levels
  output logic [7:0] bank0_pin_o,               // bank 0 out value
  output logic [7:0] bank0_pin_oe_o,            // bank 0 drive
  input wire logic [7:0] bank1_pin_i,           // bank 1 pin levels
  output logic [7:0] bank1_pin_o,               // bank 1 out value
  output logic [7:0] bank1_pin_oe_o,            // bank 1 drive
  output logic [1:0] keeper_en_o,               // per-bank keeper
  output logic [1:0] pull_en_o,                 // per-bank pull enable
  output logic [15:0] pull_up_o,                // 1 up, 0 down
  output logic alert_n_o,                       // alert out value
  output logic alert_oe_o                       // alert drive
);
  import gxr_pkg::*;

  // ==========================================================
  // synchronisers
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic [1:0] rstn_sync_reg;
  logic [3:0] apin_sync1_reg;
  logic [3:0] apin_sync2_reg;
  logic [15:0] pin_sync1_reg;
  logic [15:0] pin_sync2_reg;
  logic [15:0] pin_prev_reg;
  logic scl_prev_reg;
  logic sda_prev_reg;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      rstn_sync_reg <= 2'h0;
      apin_sync1_reg <= 4'h0;
      apin_sync2_reg <= 4'h0;
      pin_sync1_reg <= 16'h0000;
      pin_sync2_reg <= 16'h0000;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_i};
      sda_sync_reg <= {sda_sync_reg[0], sda_i};
      rstn_sync_reg <= {rstn_sync_reg[0], reset_n_pin_i};
      apin_sync1_reg <= addr_select_pin_i;
      apin_sync2_reg <= apin_sync1_reg;
      pin_sync1_reg <= {bank1_pin_i, bank0_pin_i};
      pin_sync2_reg <= pin_sync1_reg;
      scl_prev_reg <= scl_sync_reg[1];
      sda_prev_reg <= sda_sync_reg[1];
    end
  end

  // pin reset joins the system reset after its synchroniser
  wire rst = srst_i | ~rstn_sync_reg[1];
  wire scl_s = scl_sync_reg[1];
  wire sda_s = sda_sync_reg[1];
  wire scl_rise = scl_s & ~scl_prev_reg;
  wire scl_fall = ~scl_s & scl_prev_reg;
  wire start_det = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
  wire stop_det = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

  // ==========================================================
  // link state
  gxr_state_type state_reg;
  logic [7:0] shift_reg;
  logic [3:0] bit_cnt_reg;
  logic rw_reg;
  logic mnack_reg;
  logic sda_oe_reg;
  logic [7:0] cmd_reg;
  logic [7:0] cfg_reg [16];
  logic [15:0] flag_reg;

  wire [6:0] dev_addr = USE_ADDR_PINS ? {PIN_ADDR_HI, apin_sync2_reg}
                                      : FIXED_ADDR;
  wire byte_done = scl_fall & (bit_cnt_reg == GXR_BITS_PER_BYTE);
  wire addr_hit = shift_reg[7:1] == dev_addr;
  wire cmd_rsvd = |shift_reg[GXR_CMD_RSVD_MSB:GXR_CMD_RSVD_LSB];
  wire [3:0] ptr = cmd_reg[3:0];
  wire step_flag = cmd_reg[GXR_CMD_STEP_BIT];
  wire wr_stb = (state_reg == GXR_ST_WDATA) & byte_done;
  wire rd_stb = (state_reg == GXR_ST_MACK) & scl_rise;
  wire load_stb = ((state_reg == GXR_ST_ACK_ADDR) & scl_fall & rw_reg)
                | ((state_reg == GXR_ST_MACK) & scl_fall & ~mnack_reg);
  wire cmd_stb = (state_reg == GXR_ST_CMD) & byte_done & ~cmd_rsvd;
  // input and flag codes take no data
  wire wr_ok = (ptr >= GXR_REG_INV0) & (ptr <= GXR_REG_MASK1);

  // ==========================================================
  // read data path
  wire [15:0] dir_bits = {cfg_reg[GXR_REG_DIR1], cfg_reg[GXR_REG_DIR0]};
  wire [15:0] mask_bits = {cfg_reg[GXR_REG_MASK1], cfg_reg[GXR_REG_MASK0]};
  wire [7:0] lvl0 = pin_sync2_reg[7:0] ^ cfg_reg[GXR_REG_INV0];
  wire [7:0] lvl1 = pin_sync2_reg[15:8] ^ cfg_reg[GXR_REG_INV1];
  wire [7:0] rd_byte = (ptr == GXR_REG_IN0) ? lvl0
                     : (ptr == GXR_REG_IN1) ? lvl1
                     : (ptr == GXR_REG_FLAG0) ? flag_reg[7:0]
                     : (ptr == GXR_REG_FLAG1) ? flag_reg[15:8]
                     : cfg_reg[ptr];

  // ==========================================================
  // serial protocol engine
  always_ff @(posedge clk_i) begin
    if (rst) begin
      state_reg <= GXR_ST_IDLE;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
      rw_reg <= 1'b0;
      mnack_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (start_det) begin
      state_reg <= GXR_ST_ADDR;
      bit_cnt_reg <= 4'h0;
      sda_oe_reg <= 1'b0;
    end else if (stop_det) begin
      state_reg <= GXR_ST_IDLE;
      sda_oe_reg <= 1'b0;
    end else begin
      case (state_reg)
        GXR_ST_ADDR, GXR_ST_CMD, GXR_ST_WDATA: begin
          if (scl_rise && bit_cnt_reg != GXR_BITS_PER_BYTE) begin
            shift_reg <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          if (byte_done) begin
            if (state_reg == GXR_ST_ADDR) begin
              state_reg <= addr_hit ? GXR_ST_ACK_ADDR : GXR_ST_SKIP;
              sda_oe_reg <= addr_hit;
              rw_reg <= shift_reg[0];
            end else if (state_reg == GXR_ST_CMD) begin
              // reserved codes get no ack and the rest is ignored
              state_reg <= cmd_rsvd ? GXR_ST_SKIP : GXR_ST_ACK_CMD;
              sda_oe_reg <= ~cmd_rsvd;
            end else begin
              state_reg <= GXR_ST_ACK_WDATA;
              sda_oe_reg <= 1'b1;
            end
          end
        end
        GXR_ST_ACK_ADDR: begin
          if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (rw_reg) begin
              state_reg <= GXR_ST_RDATA;
              shift_reg <= rd_byte;
              sda_oe_reg <= ~rd_byte[7];
            end else begin
              state_reg <= GXR_ST_CMD;
              sda_oe_reg <= 1'b0;
            end
          end
        end
        GXR_ST_ACK_CMD, GXR_ST_ACK_WDATA: begin
          if (scl_fall) begin
            state_reg <= GXR_ST_WDATA;
            bit_cnt_reg <= 4'h0;
            sda_oe_reg <= 1'b0;
          end
        end
        GXR_ST_RDATA: begin
          if (scl_fall) begin
            if (bit_cnt_reg == GXR_LAST_TX_BIT) begin
              state_reg <= GXR_ST_MACK;
              sda_oe_reg <= 1'b0;
            end else begin
              shift_reg <= {shift_reg[6:0], 1'b1};
              sda_oe_reg <= ~shift_reg[6];
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
        end
        GXR_ST_MACK: begin
          if (scl_rise) begin
            mnack_reg <= sda_s;
          end
          if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (mnack_reg) begin
              state_reg <= GXR_ST_SKIP;
            end else begin
              state_reg <= GXR_ST_RDATA;
              shift_reg <= rd_byte;
              sda_oe_reg <= ~rd_byte[7];
            end
          end
        end
        GXR_ST_IDLE, GXR_ST_SKIP: begin
          sda_oe_reg <= 1'b0;
        end
        default: begin
          state_reg <= GXR_ST_IDLE;
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // command register and register file
  always_ff @(posedge clk_i) begin
    if (rst) begin
      cmd_reg <= GXR_CMD_RST;
    end else if (cmd_stb) begin
      cmd_reg <= shift_reg;
    end else if ((wr_stb || rd_stb) && step_flag) begin
      // four-bit add wraps fifteen to zero
      cmd_reg[3:0] <= ptr + 4'h1;
    end
  end  // step flag clear leaves the pointer alone

  always_ff @(posedge clk_i) begin
    if (rst) begin
      for (int i = 0; i < 16; i++) begin
        // all pins come up as inputs and masked
        cfg_reg[i] <= (i == GXR_REG_DIR0 || i == GXR_REG_DIR1) ? GXR_DIR_RST
                    : (i == GXR_REG_MASK0 || i == GXR_REG_MASK1) ? GXR_MASK_RST
                    : GXR_CFG_RST;
      end
    end else if (wr_stb && wr_ok) begin
      cfg_reg[ptr] <= shift_reg;
    end
  end

  // ==========================================================
  // change detection; reading an input register clears its bank
  wire [15:0] change = (pin_sync2_reg ^ pin_prev_reg) & ~mask_bits & dir_bits;
  wire [15:0] flag_clr = {{8{load_stb && ptr == GXR_REG_IN1}},
                          {8{load_stb && ptr == GXR_REG_IN0}}};
  wire clr_any = |flag_clr;

  always_ff @(posedge clk_i) begin
    if (rst) begin
      pin_prev_reg <= 16'h0000;
      flag_reg <= 16'h0000;
    end else begin
      pin_prev_reg <= pin_sync2_reg;
      flag_reg <= (flag_reg & ~flag_clr) | change;
    end
  end

  // ==========================================================
  // pads
  assign sda_o = 1'b0;
  assign sda_oe_o = sda_oe_reg;
  assign bank0_pin_o = cfg_reg[GXR_REG_OUTPUT_PORT0_VALUE];
  assign bank1_pin_o = cfg_reg[GXR_REG_OUTPUT_PORT1_VALUE];
  assign bank0_pin_oe_o = ~cfg_reg[GXR_REG_DIR0];
  assign bank1_pin_oe_o = ~cfg_reg[GXR_REG_DIR1];
  // the pad keeper is weak, so an external driver still wins
  assign keeper_en_o = {cfg_reg[GXR_REG_KEEP1][GXR_KEEP_BIT],
                        cfg_reg[GXR_REG_KEEP0][GXR_KEEP_BIT]};
  assign pull_en_o = {cfg_reg[GXR_REG_KEEP1][GXR_PULL_EN_BIT],
                      cfg_reg[GXR_REG_KEEP0][GXR_PULL_EN_BIT]} & ~keeper_en_o;
  assign pull_up_o = {cfg_reg[GXR_REG_PULL1], cfg_reg[GXR_REG_PULL0]};
  assign alert_n_o = 1'b0;
  assign alert_oe_o = |flag_reg;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  sequence s_addr_hit;
    state_reg == GXR_ST_ADDR && byte_done && addr_hit && !start_det && !stop_det;
  endsequence
  sequence s_cmd_bad;
    state_reg == GXR_ST_CMD && byte_done && cmd_rsvd && !start_det && !stop_det;
  endsequence
  sequence s_ack_fall;
    state_reg == GXR_ST_ACK_ADDR && scl_fall && !start_det && !stop_det;
  endsequence

  property p_start_addr;
    start_det && !rst |=> state_reg == GXR_ST_ADDR && bit_cnt_reg == 4'h0;
  endproperty
  a_start_addr: assert property (p_start_addr) else $error("start not taken");

  property p_addr_ack;
    s_addr_hit |=> sda_oe_reg && state_reg == GXR_ST_ACK_ADDR;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address not acked");

  property p_dir_read;
    s_addr_hit ##[1:12] s_ack_fall
      |=> (state_reg == GXR_ST_RDATA) == rw_reg;
  endproperty
  a_dir_read: assert property (p_dir_read) else $error("wrong direction");

  property p_cmd_nack;
    s_cmd_bad |=> state_reg == GXR_ST_SKIP && !sda_oe_reg;
  endproperty
  a_cmd_nack: assert property (p_cmd_nack) else $error("reserved code acked");

  property p_skip_hold;
    state_reg == GXR_ST_SKIP && !rst |=> $stable(cmd_reg);
  endproperty
  a_skip_hold: assert property (p_skip_hold) else $error("pointer moved in skip");

  property p_step;
    (wr_stb || rd_stb) && step_flag && !rst && !cmd_stb
      |=> cmd_reg[3:0] == 4'($past(cmd_reg[3:0]) + 4'h1);
  endproperty
  a_step: assert property (p_step) else $error("pointer did not step");

  property p_hold;
    (wr_stb || rd_stb) && !step_flag && !rst |=> $stable(cmd_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("pointer moved");

  property p_ro;
    wr_stb && !wr_ok && !rst
      |=> $stable({dir_bits, mask_bits, pull_up_o, keeper_en_o, pull_en_o})
          && $stable({cfg_reg[GXR_REG_INV1], cfg_reg[GXR_REG_INV0], bank1_pin_o, bank0_pin_o});
  endproperty
  a_ro: assert property (p_ro) else $error("read-only code written");

  property p_wrap;
    (wr_stb || rd_stb) && step_flag && ptr == GXR_REG_FLAG1 && !cmd_stb && !rst
      |=> ptr == GXR_REG_IN0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("pointer did not wrap");

  property p_reset_dir;
    rst |=> bank0_pin_oe_o == 8'h00 && bank1_pin_oe_o == 8'h00 && cmd_reg == 8'h00;
  endproperty
  a_reset_dir: assert property (p_reset_dir) else $error("reset defaults wrong");

  // an input read in the next cycle may legally clear the new flag
  property p_alert;
    |change && !rst |=> alert_oe_o ##1 (alert_oe_o || $past(clr_any));
  endproperty
  a_alert: assert property (p_alert) else $error("alert missing");

  property p_flag_clr;
    load_stb && ptr == GXR_REG_IN0 && !(|change[7:0]) && !rst |=> flag_reg[7:0] == 8'h00;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flags not cleared");
endmodule : gxr_expander
`default_nettype wire

/* gxr_master_model.sv */
// gxr_master_model: behavioural two-wire bus master driving the expander link
`timescale 1ns/1ps
`default_nettype none
module gxr_master_model (
  input wire logic clk_i,  // bench clock
  input wire logic sda_i,  // resolved data wire
  output logic scl_o,      // serial clock, idles high
  output logic sda_low_o   // 1 pulls data low
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // ==========================================================
  // bit timing: 1 clock to data, 3 more low, 4 high = 160 ns
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  // start or repeated start; data released first so the slave ack clears
  task automatic start_c();
    @(posedge clk_i);
    sda_low_o <= 1'b0;
    tick(4);
    scl_o <= 1'b1;
    tick(4);
    sda_low_o <= 1'b1;
    tick(4);
    scl_o <= 1'b0;
    tick(1);
  endtask : start_c
  task automatic stop_c();
    @(posedge clk_i);
    sda_low_o <= 1'b1;
    tick(4);
    scl_o <= 1'b1;
    tick(4);
    sda_low_o <= 1'b0;
    tick(8);
  endtask : stop_c
  // data changes only while the clock is low; sampled late in the high phase
  task automatic xfer_bit(input logic b, output logic r);
    @(posedge clk_i);
    sda_low_o <= ~b;
    tick(3);
    scl_o <= 1'b1;
    tick(3);
    @(negedge clk_i);
    r = sda_i;
    @(posedge clk_i);
    scl_o <= 1'b0;
  endtask : xfer_bit
  // address byte carries the direction in its last bit
  task automatic xfer_byte(input logic [7:0] d, input logic last, output logic [7:0] r,
                           output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(d[i], b);
      r[i] = b;
    end
    xfer_bit(last, ack);
  endtask : xfer_byte
endmodule : gxr_master_model
`default_nettype wire

/* gxr_pkg.sv */
// gxr_pkg: register map, reset values and command fields of the gpio expander
package gxr_pkg;
  // ==========================================================
  // register pointer codes
  localparam logic [3:0] GXR_REG_IN0 = 4'h0;
  localparam logic [3:0] GXR_REG_IN1 = 4'h1;
  localparam logic [3:0] GXR_REG_INV0 = 4'h2;
  localparam logic [3:0] GXR_REG_INV1 = 4'h3;
  localparam logic [3:0] GXR_REG_KEEP0 = 4'h4;
  localparam logic [3:0] GXR_REG_KEEP1 = 4'h5;
  localparam logic [3:0] GXR_REG_PULL0 = 4'h6;
  localparam logic [3:0] GXR_REG_PULL1 = 4'h7;
  localparam logic [3:0] GXR_REG_DIR0 = 4'h8;
  localparam logic [3:0] GXR_REG_DIR1 = 4'h9;
  localparam logic [3:0] GXR_REG_OUTPUT_PORT0_VALUE = 4'hA;
  localparam logic [3:0] GXR_REG_OUTPUT_PORT1_VALUE = 4'hB;
  localparam logic [3:0] GXR_REG_MASK0 = 4'hC;
  localparam logic [3:0] GXR_REG_MASK1 = 4'hD;
  localparam logic [3:0] GXR_REG_FLAG0 = 4'hE;
  localparam logic [3:0] GXR_REG_FLAG1 = 4'hF;
  // ==========================================================
  // command byte fields and keeper register bits
  localparam int GXR_CMD_STEP_BIT = 7;
  localparam int GXR_CMD_RSVD_MSB = 6;
  localparam int GXR_CMD_RSVD_LSB = 4;
  localparam int GXR_KEEP_BIT = 0;
  localparam int GXR_PULL_EN_BIT = 1;
  // ==========================================================
  // reset values and bit counter limits
  localparam logic [7:0] GXR_CMD_RST = 8'h00;
  localparam logic [7:0] GXR_DIR_RST = 8'hFF;
  localparam logic [7:0] GXR_MASK_RST = 8'hFF;
  localparam logic [7:0] GXR_CFG_RST = 8'h00;
  localparam logic [3:0] GXR_BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] GXR_LAST_TX_BIT = 4'h7;
  // ==========================================================
  // link states
  typedef enum logic [9:0] {
    GXR_ST_IDLE = 10'b00_0000_0001,
    GXR_ST_ADDR = 10'b00_0000_0010,
    GXR_ST_ACK_ADDR = 10'b00_0000_0100,
    GXR_ST_CMD = 10'b00_0000_1000,
    GXR_ST_ACK_CMD = 10'b00_0001_0000,
    GXR_ST_WDATA = 10'b00_0010_0000,
    GXR_ST_ACK_WDATA = 10'b00_0100_0000,
    GXR_ST_RDATA = 10'b00_1000_0000,
    GXR_ST_MACK = 10'b01_0000_0000,
    GXR_ST_SKIP = 10'b10_0000_0000
  } gxr_state_type;
endpackage : gxr_pkg

/* gxr_unused_note_placeholder.sv */
// gxr_unused_note_placeholder: empty compile unit kept intentionally minimal
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* tb_i2c_gpio_expander_regs.sv */
// tb_i2c_gpio_expander_regs: self-checking bench for the gpio expander
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_gpio_expander_regs;
  import gxr_pkg::*;
  localparam logic [6:0] DEV = 7'h25;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic rst_pin_n = 1'b1;
  logic [7:0] ext0 = 8'h00;
  logic [7:0] ext1 = 8'h00;
  logic scl, sda_low, sda_o, sda_oe, alert_n, alert_oe, a;
  logic [7:0] b0_o, b0_oe, b1_o, b1_oe, r;
  logic [1:0] keep, pull;
  logic [15:0] pup;
  logic [127:0] q;
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;
  // ==========================================================
  // wires with pull-ups; pins resolve between driver and outside world
  wire logic sda_w = ~(sda_low | (sda_oe & ~sda_o));
  wire logic alert_w = ~(alert_oe & ~alert_n);
  wire logic [7:0] lvl0 = (b0_oe & b0_o) | (~b0_oe & ext0);
  wire logic [7:0] lvl1 = (b1_oe & b1_o) | (~b1_oe & ext1);
  always #10 clk = ~clk;
  gxr_master_model m (.clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_low_o(sda_low));
  gxr_expander #(.USE_ADDR_PINS(1'b1), .FIXED_ADDR(7'h20), .PIN_ADDR_HI(3'h2)) uut (
    .clk_i(clk), .srst_i(srst), .reset_n_pin_i(rst_pin_n), .addr_select_pin_i(4'h5),
    .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .bank0_pin_i(lvl0), .bank0_pin_o(b0_o), .bank0_pin_oe_o(b0_oe),
    .bank1_pin_i(lvl1), .bank1_pin_o(b1_o), .bank1_pin_oe_o(b1_oe),
    .keeper_en_o(keep), .pull_en_o(pull), .pull_up_o(pup),
    .alert_n_o(alert_n), .alert_oe_o(alert_oe));
  // ==========================================================
  // checking and access tasks
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude
  task automatic addr_cmd(input logic [7:0] cmd, input logic cmd_ok);
    m.start_c();
    m.xfer_byte({DEV, 1'b0}, 1'b1, r, a);
    chk(a, 1'b0);
    m.xfer_byte(cmd, 1'b1, r, a);
    chk(a, !cmd_ok);
  endtask : addr_cmd
  task automatic wr(input logic [7:0] cmd, input logic [63:0] d, input int n);
    addr_cmd(cmd, 1'b1);
    for (int i = 0; i < n; i++) begin
      m.xfer_byte(d[8 * i +: 8], 1'b1, r, a);
      chk(a, 1'b0);
    end
    m.stop_c();
  endtask : wr
  // without a command the stored pointer selects the register
  task automatic rd(input logic use_cmd, input logic [7:0] cmd, input int n);
    q = '0;
    if (use_cmd) begin
      addr_cmd(cmd, 1'b1);
    end
    m.start_c();
    m.xfer_byte({DEV, 1'b1}, 1'b1, r, a);
    chk(a, 1'b0);
    for (int i = 0; i < n; i++) begin
      m.xfer_byte(8'hFF, i == n - 1, r, a);
      q[8 * i +: 8] = r;
    end
    m.stop_c();
  endtask : rd
  // ==========================================================
  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      error_cnt++;
      conclude();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    repeat (10) @(posedge clk);
    chk(b0_oe | b1_oe, 8'h00);
    chk(alert_w, 1'b1);
    rd(1'b1, 8'h82, 12);
    chk(q, {32'h0, GXR_MASK_RST, GXR_MASK_RST, 16'h0000, GXR_DIR_RST, GXR_DIR_RST, 48'h0});
    wr(8'h8E, 64'h0000_2211_5A5A_5A5A, 6);
    rd(1'b1, 8'h82, 2);
    chk(q, 128'h2211);
    rd(1'b1, 8'h8E, 2);
    chk(q, 128'h0000);
    wr(8'h0A, 64'h003C_5AA5, 3);
    chk(b0_o, 8'h3C);
    rd(1'b1, 8'h0A, 2);
    chk(q, 128'h3C3C);
    rd(1'b1, 8'h0B, 1);
    chk(q, 128'h0000);
    wr(8'h88, 64'hF00F, 2);
    chk({b1_oe, b0_oe}, 16'h0FF0);
    ext0 <= 8'h96;
    ext1 <= 8'h3C;
    repeat (10) @(posedge clk);
    chk(alert_w, 1'b1);
    rd(1'b1, 8'h80, 2);
    chk(q, 128'h1227);
    wr(8'h84, 64'h55AA_0203, 4);
    chk({pup, pull, keep}, 20'h5_5AA9);
    wr(8'h0C, 64'hFE, 1);
    ext0 <= 8'h97;
    repeat (10) @(posedge clk);
    chk(alert_w, 1'b0);
    rd(1'b1, 8'h0E, 1);
    chk(q, 128'h01);
    rd(1'b1, 8'h00, 1);
    chk(q, 128'h26);
    chk(alert_w, 1'b1);
    for (int c = 0; c < 16; c++) begin
      addr_cmd({4'h0, c[3:0]}, 1'b1);
      m.stop_c();
    end
    addr_cmd(8'h0B, 1'b1);
    m.stop_c();
    for (int c = 1; c < 8; c++) begin
      addr_cmd({1'b0, c[2:0], 4'h0}, 1'b0);
      m.xfer_byte(8'h77, 1'b1, r, a);
      chk(a, 1'b1);
      m.stop_c();
    end
    rd(1'b0, 8'h00, 1);
    chk(q, 128'h00);
    m.start_c();
    m.xfer_byte({7'h20, 1'b0}, 1'b1, r, a);
    chk(a, 1'b1);
    m.stop_c();
    rst_pin_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_pin_n <= 1'b1;
    repeat (10) @(posedge clk);
    chk({b1_oe, b0_oe, keep, pull}, 20'h0);
    rd(1'b0, 8'h00, 1);
    chk(q, 128'h97);
    rd(1'b1, 8'h8A, 2);
    chk(q, 128'h0);
    wr(8'h0B, 64'h81, 1);
    chk(b1_o, 8'h81);
    conclude();
  end
endmodule : tb_i2c_gpio_expander_regs
`default_nettype wire
